// ### hw/fcgu_unit.sv
// float compare unit top: issue decode, result and status-word flags, wishbone registers
// How it works
// RQ1 - greater-or-equal op writes 1 when source one >= source two, else 0
// RQ2 - greater-than op writes 1 when source one > source two, else 0
// RQ3 - operands are single-precision floats; result is an integer
// RQ4 - denormal operands become zero; compares then set input-flushed flag in status word
// RQ5 - exceptions a compare raises set the matching status-word flags
// RQ6 - status flags are sticky; only the explicit status-word write clears them
// RQ7 - flag update lands with the result write, one cycle after issue
// RQ8 - concurrent flag updates OR together with the existing flag value
// RQ9 - guarded compare writes result and flags only when guard bit 0 is 1
// RQ10 - flag-only op returns the compare's exception flags as a vector
// RQ11 - flag-only op never changes the status-word flags
// RQ12 - vector layout matches status word; bits 31 to 7 are zero
// RQ13 - flag-only op flushes denormals and sets input-flushed bit in vector
// RQ14 - guarded flag-only op writes destination only when guard bit 0 is 1
// RQ15 - NaN comparison gives 0 and raises invalid, bit 4
// RQ16 - infinities are ordered; +inf >= +inf, not > +inf, no flags
// RQ17 - less-or-equal is the greater-or-equal op with operands swapped
// RQ18 - compare result sits in bit 0, upper bits cleared
module fcgu_unit #(
   parameter int unsigned TAG_W = 7  // destination register index width
) (
   input  wire logic                    clk_i,               // core clock
   input  wire logic                    rst_i,               // synchronous reset, active high
   input  wire logic                    ce_i,                // clock enable, freezes all state when low; synchronous reset still applies
   // issue side
   input  wire logic                    issue_valid_i,       // operation issued this cycle
   input  wire logic [7:0]              opcode_i,            // operation code
   input  wire logic                    guarded_i,           // operation carries a guard
   input  wire logic [31:0]             guard_i,             // guard register value
   input  wire logic [31:0]             source_one_i,        // first source operand
   input  wire logic [31:0]             source_two_i,        // second source operand
   input  wire logic [TAG_W-1:0]        dest_i,              // destination register index
   // result side
   output logic                         result_valid_o,      // operation retired this cycle
   output logic                         result_write_o,      // destination is written
   output logic [TAG_W-1:0]             result_dest_o,       // destination register index
   output logic [31:0]                  result_data_o,       // destination value
   // status word exception flags
   input  wire logic                    psw_write_i,         // explicit status-word write
   input  wire logic [6:0]              psw_write_data_i,    // flags written by it
   input  wire logic [6:0]              other_flag_set_i,    // concurrent sets from other units
   output logic [6:0]                   processor_status_word_o, // sticky exception flags
   // wishbone slave
   input  wire logic                    wb_cyc_i,            // bus cycle
   input  wire logic                    wb_stb_i,            // strobe
   input  wire logic                    wb_we_i,             // write enable
   input  wire logic [7:0]              wb_adr_i,            // byte address
   input  wire logic [3:0]              wb_sel_i,            // byte selects
   input  wire logic [31:0]             wb_dat_i,            // write data
   output logic [31:0]                  wb_dat_o,            // read data
   output logic                         wb_ack_o,            // acknowledge
   output logic                         irq_o                // level interrupt
);

   function automatic fcgu_pkg::fcgu_op_type op_decode(input logic [7:0] opc);
      if (opc == fcgu_pkg::OPC_GTR) begin
         op_decode = fcgu_pkg::FCGU_OP_GTR;
      end else if (opc == fcgu_pkg::OPC_GEQ) begin
         op_decode = fcgu_pkg::FCGU_OP_GEQ;
      end else if (opc == fcgu_pkg::OPC_GEQ_FLAGS) begin
         op_decode = fcgu_pkg::FCGU_OP_GEQ_FLAGS;
      end else begin
         op_decode = fcgu_pkg::FCGU_OP_NONE;
      end
   endfunction

   // byte-lane merge used by the control register; mask and status take lane 0 only
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      lane_merge = r;
   endfunction

   fcgu_pkg::fcgu_op_type op;
   logic                  ge;
   logic                  gt;
   logic [6:0]            cmp_flags;
   logic                  enabled;
   logic                  take;
   logic                  guard_ok;
   logic                  commit;
   logic                  illegal;
   logic                  cmp_commit;
   logic [31:0]           result_d;
   logic [6:0]            own_set;
   logic [6:0]            psw_d;

   logic                  result_valid_q;
   logic                  result_write_q;
   logic [TAG_W-1:0]      result_dest_q;
   logic [31:0]           result_data_q;
   logic [6:0]            psw_q;

   logic [31:0]           ctrl_q;
   logic [2:0]            irq_status_q;
   logic [2:0]            irq_mask_q;
   logic [2:0]            irq_event;
   logic [15:0]           op_count_q;
   logic [15:0]           skip_count_q;
   logic                  wb_ack_q;
   logic [31:0]           wb_dat_q;
   logic                  wb_req;
   logic                  wb_wr;

   fcgu_cmp_core u_core (
      .source_one_i (source_one_i),
      .source_two_i (source_two_i),
      .ge_o         (ge),
      .gt_o         (gt),
      .flags_o      (cmp_flags)
   );

   assign op       = op_decode(opcode_i);
   assign enabled  = ctrl_q[fcgu_pkg::CTRL_ENABLE_BIT];
   // a disabled unit ignores issues entirely; software must not issue then
   assign take     = issue_valid_i && enabled && (op != fcgu_pkg::FCGU_OP_NONE);
   assign illegal  = issue_valid_i && enabled && (op == fcgu_pkg::FCGU_OP_NONE);
   assign guard_ok = !guarded_i || guard_i[0];                          // RQ9 RQ14
   assign commit   = take && guard_ok;                                  // RQ9 RQ14
   assign cmp_commit = commit && (op != fcgu_pkg::FCGU_OP_GEQ_FLAGS);   // RQ11

   always_comb begin
      result_d = fcgu_pkg::INT_ZERO;
      case (op)
         fcgu_pkg::FCGU_OP_GEQ: begin
            result_d = ge ? fcgu_pkg::INT_ONE : fcgu_pkg::INT_ZERO;     // RQ1 RQ17 RQ18
         end
         fcgu_pkg::FCGU_OP_GTR: begin
            result_d = gt ? fcgu_pkg::INT_ONE : fcgu_pkg::INT_ZERO;     // RQ2 RQ18
         end
         fcgu_pkg::FCGU_OP_GEQ_FLAGS: begin
            result_d = {25'h000_0000, cmp_flags};                       // RQ10 RQ12 RQ13
         end
         default: begin
            result_d = fcgu_pkg::INT_ZERO;
         end
      endcase
   end

   // flags raised by this unit's own compare, only when it really commits
   assign own_set = cmp_commit ? cmp_flags : fcgu_pkg::FLAGS_NONE;      // RQ5 RQ9 RQ11

   // explicit write replaces, then every set is ORed on top so no set is lost
   assign psw_d = (psw_write_i ? psw_write_data_i : psw_q) | other_flag_set_i | own_set; // RQ6 RQ8

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_valid_q <= 1'b0;
         result_write_q <= 1'b0;
      end else if (ce_i) begin
         result_valid_q <= take;
         result_write_q <= commit;                                      // RQ7 RQ9 RQ14
      end
   end

   // destination value holds when a guard suppresses the write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_dest_q <= '0;
         result_data_q <= fcgu_pkg::INT_ZERO;
      end else if (ce_i && commit) begin
         result_dest_q <= dest_i;
         result_data_q <= result_d;                                     // RQ7
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         psw_q <= fcgu_pkg::FLAGS_NONE;
      end else if (ce_i) begin
         psw_q <= psw_d;                                                // RQ5 RQ6 RQ7 RQ8
      end
   end

   assign result_valid_o          = result_valid_q;
   assign result_write_o          = result_write_q;
   assign result_dest_o           = result_dest_q;
   assign result_data_o           = result_data_q;
   assign processor_status_word_o = psw_q;

   // statistics
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_count_q   <= fcgu_pkg::COUNT_ZERO;
         skip_count_q <= fcgu_pkg::COUNT_ZERO;
      end else if (ce_i) begin
         if (commit) begin
            op_count_q <= op_count_q + fcgu_pkg::COUNT_ONE;
         end
         if (take && !guard_ok) begin
            skip_count_q <= skip_count_q + fcgu_pkg::COUNT_ONE;
         end
      end
   end

   // interrupt events: any committed op that raises invalid or flush, and unknown opcodes
   always_comb begin
      irq_event = fcgu_pkg::IRQ_NONE;
      irq_event[fcgu_pkg::IRQ_INVALID_BIT] = commit && cmp_flags[fcgu_pkg::INVALID_BIT];
      irq_event[fcgu_pkg::IRQ_FLUSH_BIT]   = commit && cmp_flags[fcgu_pkg::INPUT_FLUSHED_ZERO_BIT];
      irq_event[fcgu_pkg::IRQ_ILLEGAL_BIT] = illegal;
   end

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_q;
   assign wb_wr  = wb_req && wb_we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= fcgu_pkg::CTRL_RESET;
      end else if (ce_i && wb_wr && (wb_adr_i == fcgu_pkg::REG_CTRL)) begin
         ctrl_q <= lane_merge(ctrl_q, wb_dat_i, wb_sel_i) & fcgu_pkg::INT_ONE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_q <= fcgu_pkg::IRQ_NONE;
      end else if (ce_i && wb_wr && (wb_adr_i == fcgu_pkg::REG_IRQ_MASK) && wb_sel_i[0]) begin
         irq_mask_q <= wb_dat_i[2:0];
      end
   end

   // write-one-to-clear; a new event in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_q <= fcgu_pkg::IRQ_NONE;
      end else if (ce_i) begin
         if (wb_wr && (wb_adr_i == fcgu_pkg::REG_IRQ_STATUS) && wb_sel_i[0]) begin
            irq_status_q <= (irq_status_q & ~wb_dat_i[2:0]) | irq_event;
         end else begin
            irq_status_q <= irq_status_q | irq_event;
         end
      end
   end

   assign irq_o = |(irq_status_q & irq_mask_q);

   // one wait state: ack and read data registered, ack drops the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= fcgu_pkg::INT_ZERO;
      end else if (ce_i) begin
         wb_ack_q <= wb_req;
         if (wb_req && !wb_we_i) begin
            if (wb_adr_i == fcgu_pkg::REG_CTRL) begin
               wb_dat_q <= ctrl_q;
            end else if (wb_adr_i == fcgu_pkg::REG_IRQ_STATUS) begin
               wb_dat_q <= {29'h0000_0000, irq_status_q};
            end else if (wb_adr_i == fcgu_pkg::REG_IRQ_MASK) begin
               wb_dat_q <= {29'h0000_0000, irq_mask_q};
            end else if (wb_adr_i == fcgu_pkg::REG_FLAGS) begin
               wb_dat_q <= {25'h000_0000, psw_q};
            end else if (wb_adr_i == fcgu_pkg::REG_OP_COUNT) begin
               wb_dat_q <= {16'h0000, op_count_q};
            end else if (wb_adr_i == fcgu_pkg::REG_SKIP_COUNT) begin
               wb_dat_q <= {16'h0000, skip_count_q};
            end else if (wb_adr_i == fcgu_pkg::REG_LAST_RESULT) begin
               wb_dat_q <= result_data_q;
            end else begin
               wb_dat_q <= fcgu_pkg::INT_ZERO;
            end
         end
      end
   end

   assign wb_ack_o = wb_ack_q;
   assign wb_dat_o = wb_dat_q;

endmodule

// ### hw/fcgu_pkg.sv
// shared constants and types of the float compare greater-or-equal / greater-than unit
package fcgu_pkg;

   // data path widths
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned FLAG_W   = 7;
   localparam int unsigned OPC_W    = 8;
   localparam int unsigned EXP_W    = 8;
   localparam int unsigned MANT_W   = 23;
   localparam int unsigned SIGN_BIT = 31;

   // operation codes handled by this unit
   localparam logic [OPC_W-1:0] OPC_GTR       = 8'h90;  // strict greater-than compare
   localparam logic [OPC_W-1:0] OPC_GEQ       = 8'h92;  // greater-or-equal compare
   localparam logic [OPC_W-1:0] OPC_GEQ_FLAGS = 8'h93;  // flag-only greater-or-equal

   // exception flag layout, shared by the status word and the flag vector
   localparam int unsigned OUTPUT_FLUSHED_ZERO_BIT = 6;
   localparam int unsigned INPUT_FLUSHED_ZERO_BIT  = 5;
   localparam int unsigned INVALID_BIT             = 4;
   localparam int unsigned OVERFLOW_BIT            = 3;
   localparam int unsigned UNDERFLOW_BIT           = 2;
   localparam int unsigned INEXACT_BIT             = 1;
   localparam int unsigned DIVIDE_BY_ZERO_BIT      = 0;

   // float field constants
   localparam logic [EXP_W-1:0]  EXP_ZERO   = 8'h00;
   localparam logic [EXP_W-1:0]  EXP_MAX    = 8'hff;
   localparam logic [MANT_W-1:0] MANT_ZERO  = 23'h00_0000;
   localparam logic [DATA_W-1:0] FLOAT_ZERO = 32'h0000_0000;
   localparam logic [DATA_W-1:0] SIGN_MASK  = 32'h8000_0000;
   localparam logic [DATA_W-1:0] INT_ONE    = 32'h0000_0001;
   localparam logic [DATA_W-1:0] INT_ZERO   = 32'h0000_0000;
   localparam logic [FLAG_W-1:0] FLAGS_NONE = 7'h00;

   // wishbone register map (byte addresses)
   localparam int unsigned       WB_ADDR_W       = 8;
   localparam logic [7:0]        REG_CTRL        = 8'h00;
   localparam logic [7:0]        REG_IRQ_STATUS  = 8'h04;
   localparam logic [7:0]        REG_IRQ_MASK    = 8'h08;
   localparam logic [7:0]        REG_FLAGS       = 8'h0c;
   localparam logic [7:0]        REG_OP_COUNT    = 8'h10;
   localparam logic [7:0]        REG_SKIP_COUNT  = 8'h14;
   localparam logic [7:0]        REG_LAST_RESULT = 8'h18;

   localparam int unsigned       CTRL_ENABLE_BIT = 0;
   localparam logic [DATA_W-1:0] CTRL_RESET      = 32'h0000_0001;

   // interrupt status / mask layout
   localparam int unsigned       IRQ_W           = 3;
   localparam int unsigned       IRQ_INVALID_BIT = 0;
   localparam int unsigned       IRQ_FLUSH_BIT   = 1;
   localparam int unsigned       IRQ_ILLEGAL_BIT = 2;
   localparam logic [IRQ_W-1:0]  IRQ_NONE        = 3'h0;

   localparam int unsigned       COUNT_W         = 16;
   localparam logic [15:0]       COUNT_ONE       = 16'h0001;
   localparam logic [15:0]       COUNT_ZERO      = 16'h0000;

   typedef enum logic [1:0] {
      FCGU_OP_NONE,
      FCGU_OP_GTR,
      FCGU_OP_GEQ,
      FCGU_OP_GEQ_FLAGS
   } fcgu_op_type;

endpackage

// ### hw/fcgu_cmp_core.sv
// combinational single-precision ordered compare with flush and flag generation
module fcgu_cmp_core (
   input  wire logic [31:0] source_one_i,  // first operand, raw float bits
   input  wire logic [31:0] source_two_i,  // second operand, raw float bits
   output logic             ge_o,          // source one >= source two
   output logic             gt_o,          // source one > source two
   output logic [6:0]       flags_o        // flag vector of the compare
);

   function automatic logic is_denorm(input logic [31:0] x);
      is_denorm = (x[30:23] == fcgu_pkg::EXP_ZERO) && (x[22:0] != fcgu_pkg::MANT_ZERO);
   endfunction

   function automatic logic is_nan(input logic [31:0] x);
      is_nan = (x[30:23] == fcgu_pkg::EXP_MAX) && (x[22:0] != fcgu_pkg::MANT_ZERO);
   endfunction

   // denormals and both zeros become +0, so -0 and +0 compare equal
   function automatic logic [31:0] flush(input logic [31:0] x);
      if (x[30:23] == fcgu_pkg::EXP_ZERO) begin
         flush = fcgu_pkg::FLOAT_ZERO;
      end else begin
         flush = x;
      end
   endfunction

   // sign-magnitude to unsigned ordered key; infinities stay ordered
   function automatic logic [31:0] order_key(input logic [31:0] x);
      if (x[fcgu_pkg::SIGN_BIT]) begin
         order_key = ~x;
      end else begin
         order_key = x | fcgu_pkg::SIGN_MASK;
      end
   endfunction

   logic [31:0] key_one;
   logic [31:0] key_two;
   logic        any_nan;
   logic        any_denorm;

   assign key_one    = order_key(flush(source_one_i));  // RQ3 RQ4 RQ16
   assign key_two    = order_key(flush(source_two_i));
   assign any_nan    = is_nan(source_one_i) || is_nan(source_two_i);
   assign any_denorm = is_denorm(source_one_i) || is_denorm(source_two_i);

   always_comb begin
      flags_o = fcgu_pkg::FLAGS_NONE;
      flags_o[fcgu_pkg::INVALID_BIT]            = any_nan;     // RQ15
      flags_o[fcgu_pkg::INPUT_FLUSHED_ZERO_BIT] = any_denorm;  // RQ4 RQ13
      ge_o = !any_nan && (key_one >= key_two);                 // RQ1 RQ15
      gt_o = !any_nan && (key_one > key_two);                  // RQ2 RQ16
   end

endmodule

// ### testbench/fcgu_unit_chk.sv
// port-level assertions of the float compare unit
module fcgu_unit_chk (
   input wire logic        clk_i,                   // core clock
   input wire logic        rst_i,                   // sync reset
   input wire logic        issue_valid_i,           // op issued
   input wire logic [7:0]  opcode_i,                // operation code
   input wire logic        guarded_i,               // op has a guard
   input wire logic [31:0] guard_i,                 // guard value
   input wire logic [31:0] source_two_i,            // second operand
   input wire logic        result_valid_o,          // op retired
   input wire logic        result_write_o,          // destination written
   input wire logic [31:0] result_data_o,           // destination value
   input wire logic        psw_write_i,             // explicit status write
   input wire logic [6:0]  other_flag_set_i,        // sets from other units
   input wire logic [6:0]  processor_status_word_o  // sticky flags
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic is_cmp;
   logic is_flg;
   logic ok_g;
   logic quiet;
   assign is_cmp = opcode_i == fcgu_pkg::OPC_GEQ || opcode_i == fcgu_pkg::OPC_GTR;
   assign is_flg = opcode_i == fcgu_pkg::OPC_GEQ_FLAGS;
   assign ok_g   = !guarded_i || guard_i[0];
   // other sources silent, so any flag change would be this unit's own
   assign quiet  = !psw_write_i && other_flag_set_i == 7'h00;
   a_result_one_cycle: assert property (issue_valid_i && (is_cmp || is_flg) |=> result_valid_o)
      else $error("no result one cycle after a legal issue");
   a_write_needs_guard: assert property (result_write_o |-> $past(ok_g))
      else $error("destination written under a false guard");
   a_skip_no_write: assert property (issue_valid_i && is_flg && !ok_g |=> !result_write_o)
      else $error("flag-only op wrote under a false guard");
   a_compare_is_bool: assert property (result_write_o && $past(is_cmp) |-> result_data_o[31:1] == 31'h0000_0000)
      else $error("compare result not 0 or 1");
   a_vector_upper_zero: assert property (result_write_o && $past(is_flg) |-> result_data_o[31:7] == 25'h000_0000)
      else $error("flag vector upper bits set");
   a_flag_op_psw: assert property (issue_valid_i && is_flg && quiet |=> $stable(processor_status_word_o))
      else $error("flag-only op changed status word");
   a_skip_keeps_psw: assert property (issue_valid_i && !ok_g && quiet |=> $stable(processor_status_word_o))
      else $error("skipped op changed status word");
   a_psw_sticky: assert property (!psw_write_i |=>
      (processor_status_word_o & $past(processor_status_word_o)) == $past(processor_status_word_o))
      else $error("status flag cleared without a write");
   a_psw_or_sets: assert property (1'b1 |=>
      (processor_status_word_o & $past(other_flag_set_i)) == $past(other_flag_set_i))
      else $error("concurrent flag set lost");
   a_nan_false: assert property (issue_valid_i && is_cmp && ok_g && source_two_i == 32'hffff_ffff
      |=> result_data_o == 32'h0000_0000 && processor_status_word_o[4])
      else $error("nan compare not false with invalid");
   c_guard_skip: cover property (result_valid_o && !result_write_o);
   c_flag_op: cover property (result_write_o && $past(is_flg));
   c_nan_cmp: cover property (issue_valid_i && is_cmp && source_two_i == 32'hffff_ffff);
endmodule

bind fcgu_unit fcgu_unit_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .issue_valid_i(issue_valid_i), .opcode_i(opcode_i),
   .guarded_i(guarded_i), .guard_i(guard_i), .source_two_i(source_two_i),
   .result_valid_o(result_valid_o), .result_write_o(result_write_o), .result_data_o(result_data_o),
   .psw_write_i(psw_write_i), .other_flag_set_i(other_flag_set_i),
   .processor_status_word_o(processor_status_word_o)
);

// ### testbench/fcgu_regfile_model.sv
// register-file model that takes the unit's retired results
module fcgu_regfile_model #(
   parameter int unsigned TAG_W = 7,              // destination index width
   parameter logic [31:0] FILL  = 32'h5a5a_5a5a   // initial content, shows untouched entries
) (
   input  wire logic             clk_i,     // core clock
   input  wire logic             write_i,   // destination written
   input  wire logic [TAG_W-1:0] dest_i,    // destination index
   input  wire logic [31:0]      data_i,    // destination value
   input  wire logic [TAG_W-1:0] rd_idx_i,  // read index
   output logic      [31:0]      rd_data_o  // read value
);
   logic [31:0] regs_q [2**TAG_W];
   initial begin
      foreach (regs_q[i]) regs_q[i] = FILL;
   end
   always @(posedge clk_i) begin
      if (write_i) begin
         regs_q[dest_i] <= data_i;
      end
   end
   assign rd_data_o = regs_q[rd_idx_i];
endmodule

// ### testbench/fcgu_unit_test.sv
// self-checking bench of the float compare unit
module fcgu_unit_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0]  op;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] d;
      logic [6:0]  f;
   } fcgu_row_type;
   localparam logic [7:0]  GE = fcgu_pkg::OPC_GEQ;
   localparam logic [7:0]  GT = fcgu_pkg::OPC_GTR;
   localparam logic [7:0]  FL = fcgu_pkg::OPC_GEQ_FLAGS;
   localparam logic [31:0] T3 = 32'h4040_0000;
   localparam logic [31:0] T1 = 32'h3f80_0000;
   localparam logic [31:0] ZP = 32'h0000_0000;
   localparam logic [31:0] ZN = 32'h8000_0000;
   localparam logic [31:0] QN = 32'hffff_ffff;
   localparam logic [31:0] PI = 32'h7f80_0000;
   localparam logic [31:0] NI = 32'hff80_0000;
   localparam logic [31:0] DN = 32'h0040_0000;
   localparam logic [31:0] O1 = 32'h0000_0001;
   localparam logic [31:0] O0 = 32'h0000_0000;
   localparam logic [31:0] FILL = 32'h5a5a_5a5a;
   fcgu_row_type rows [24] = '{
      '{GE, T3, ZP, O1, 7'h00}, '{GE, T3, T3, O1, 7'h00}, '{GE, T1, T3, O0, 7'h00}, '{GE, T3, T1, O1, 7'h00},
      '{GE, T3, QN, O0, 7'h10}, '{GE, PI, NI, O1, 7'h00}, '{GE, T1, DN, O1, 7'h20}, '{GE, PI, PI, O1, 7'h00},
      '{GE, ZN, ZP, O1, 7'h00}, '{GT, T3, ZP, O1, 7'h00}, '{GT, T3, T3, O0, 7'h00}, '{GT, T1, T3, O0, 7'h00},
      '{GT, T3, T1, O1, 7'h00}, '{GT, T3, QN, O0, 7'h10}, '{GT, PI, NI, O1, 7'h00}, '{GT, T1, DN, O1, 7'h20},
      '{GT, PI, PI, O0, 7'h00}, '{GT, ZN, ZP, O0, 7'h00}, '{FL, T3, ZP, O0, 7'h00}, '{FL, T3, T3, O0, 7'h00},
      '{FL, T3, QN, 32'h0000_0010, 7'h00}, '{FL, PI, NI, O0, 7'h00}, '{FL, T1, DN, 32'h0000_0020, 7'h00},
      '{FL, PI, PI, O0, 7'h00}};
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, iv = 1'b0, gd = 1'b0, psww = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, rv, rw, ack, irq;
   logic [7:0] op = 8'h00, adr = 8'h00;
   logic [31:0] gv = O0, s1 = O0, s2 = O0, wdat = O0, rdat, wbd, rf, q;
   logic [6:0] dst = 7'h00, rdst, pswd = 7'h00, oth = 7'h00, psw;
   int miscompares = 0;
   int num_checks = 0;
   always #10 clk = ~clk;
   fcgu_unit u_dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .issue_valid_i(iv), .opcode_i(op), .guarded_i(gd),
      .guard_i(gv), .source_one_i(s1), .source_two_i(s2), .dest_i(dst), .result_valid_o(rv),
      .result_write_o(rw), .result_dest_o(rdst), .result_data_o(rdat), .psw_write_i(psww),
      .psw_write_data_i(pswd), .other_flag_set_i(oth), .processor_status_word_o(psw), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wbd),
      .wb_ack_o(ack), .irq_o(irq));
   fcgu_regfile_model #(.TAG_W(7), .FILL(FILL)) u_rf (.clk_i(clk), .write_i(rw), .dest_i(rdst),
      .data_i(rdat), .rd_idx_i(dst), .rd_data_o(rf));
   task automatic conclude();
      if (miscompares == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one classic cycle; the wait is bounded so a dead slave ends the run
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         miscompares++;
         conclude();
      end
      r = wbd;
      @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic issue(input logic [7:0] o, input logic [31:0] a, input logic [31:0] b, input logic g,
                        input logic [31:0] gval, input logic clr, input logic [6:0] os);
      @(posedge clk);
      iv <= 1'b1;
      op <= o;
      s1 <= a;
      s2 <= b;
      gd <= g;
      gv <= gval;
      dst <= dst + 7'h01;
      psww <= clr;
      oth <= os;
      @(posedge clk);
      iv <= 1'b0;
      psww <= 1'b0;
      oth <= 7'h00;
      #1;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      #1;
      check("reset valid", 32'(rv), O0);
      check("reset status", 32'(psw), O0);
      check("reset irq", 32'(irq), O0);
      wb(1'b0, fcgu_pkg::REG_CTRL, O0, q);
      check("ctrl", q, O1);
      for (int i = 0; i < 24; i++) begin
         issue(rows[i].op, rows[i].a, rows[i].b, 1'b0, O0, 1'b1, 7'h00);
         check("write", 32'(rw), O1);
         check("result", rdat, rows[i].d);
         check("status", 32'(psw), 32'(rows[i].f));
         @(posedge clk);
         #1;
         check("regfile", rf, rows[i].d);
      end
      // guard bit clear but upper bits set: only bit 0 may count
      issue(GE, T3, QN, 1'b1, 32'hffff_fffe, 1'b1, 7'h00);
      check("skip valid", 32'(rv), O1);
      check("skip write", 32'(rw), O0);
      check("skip status", 32'(psw), O0);
      @(posedge clk);
      #1;
      check("skip regfile", rf, FILL);
      issue(FL, T3, QN, 1'b1, 32'hffff_fffe, 1'b0, 7'h00);
      @(posedge clk);
      #1;
      check("flag skip regfile", rf, FILL);
      issue(GT, T3, T1, 1'b1, O1, 1'b0, 7'h00);
      check("guard true", rdat, O1);
      issue(GE, T3, QN, 1'b0, O0, 1'b0, 7'h01);
      check("or status", 32'(psw), 32'h0000_0011);
      @(posedge clk);
      #1;
      check("sticky status", 32'(psw), 32'h0000_0011);
      issue(FL, T1, DN, 1'b0, O0, 1'b0, 7'h00);
      check("vector", rdat, 32'h0000_0020);
      check("vector status", 32'(psw), 32'h0000_0011);
      @(posedge clk);
      iv <= 1'b1;
      op <= GT;
      s1 <= T1;
      s2 <= T3;
      @(posedge clk);
      op <= GE;
      s1 <= T3;
      s2 <= T1;
      #1;
      check("first of pair", rdat, O0);
      @(posedge clk);
      iv <= 1'b0;
      #1;
      check("swapped geq", rdat, O1);
      wb(1'b1, fcgu_pkg::REG_IRQ_MASK, 32'h0000_0007, q);
      @(posedge clk);
      #1;
      check("irq raised", 32'(irq), O1);
      wb(1'b0, fcgu_pkg::REG_IRQ_STATUS, O0, q);
      check("irq status", q, 32'h0000_0003);
      wb(1'b0, fcgu_pkg::REG_FLAGS, O0, q);
      check("flags reg", q, 32'h0000_0011);
      wb(1'b1, fcgu_pkg::REG_IRQ_STATUS, 32'h0000_0007, q);
      @(posedge clk);
      #1;
      check("irq cleared", 32'(irq), O0);
      issue(8'h91, T3, T1, 1'b0, O0, 1'b0, 7'h00);
      check("illegal valid", 32'(rv), O0);
      wb(1'b0, fcgu_pkg::REG_IRQ_STATUS, O0, q);
      check("illegal status", q, 32'h0000_0004);
      check("illegal irq", 32'(irq), O1);
      wb(1'b0, 8'h40, O0, q);
      check("unmapped read", q, O0);
      conclude();
   end
endmodule
